// >>> inc/cfsr_consts.svh
// Register offsets, field positions and reset values for the charger fault and status registers.
`ifndef CFSR_CONSTS_SVH
`define CFSR_CONSTS_SVH

// -----------------------------------------------------------------------------
// Register offsets on the device register port
// -----------------------------------------------------------------------------
`define CFSR_ADDR_EVENTS 8'h0A
`define CFSR_ADDR_FAULT2 8'h0C
`define CFSR_ADDR_STATUS0 8'h0D
`define CFSR_ADDR_STATUS1 8'h0E
`define CFSR_ADDR_ADC_I 8'h10
`define CFSR_ADDR_ADC_V 8'h11

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define CFSR_F2_RESIDUAL 5
`define CFSR_F2_THERMAL 3
`define CFSR_F2_INOV 2
`define CFSR_F2_DATAOV 1
`define CFSR_ST0_SINK 4
`define CFSR_ST0_CHARGE 3
`define CFSR_ST0_SAFE 2
`define CFSR_ST0_POWER 0
`define CFSR_EV_CHANGE 5
`define CFSR_EV_ADC 0

// -----------------------------------------------------------------------------
// Reset value and live-bit masks
// -----------------------------------------------------------------------------
`define CFSR_RST_BYTE 8'h00
`define CFSR_F2_USED 8'h2E
`define CFSR_ST0_USED 8'h1D
`define CFSR_EV_USED 8'h21

`endif

// >>> inc/cfsr_pkg.sv
// Types shared by the charger fault and status register block.
package cfsr_pkg;

  // Eight-bit register value.
  typedef logic [7:0] cfsr_byte_t;

  // Encoded Type-C connection state as reported in the status register.
  typedef enum logic [3:0] {
    CFSR_CC_DISABLED = 4'h0,
    CFSR_CC_ERR_RECOVERY = 4'h2,
    CFSR_CC_UNATTACHED = 4'h3,
    CFSR_TYPEC_SINK_PRESENT_WAIT = 4'h6,
    CFSR_CC_ATTACHED_CC2 = 4'h8,
    CFSR_CC_ATTACHED_CC1 = 4'hC
  } cfsr_connection_state_code_e;

endpackage : cfsr_pkg

// >>> rtl/cfsr_regs.sv
// Fault, event, status and measurement registers of the charging-port controller.
//
// Overview of operation
// - Masked second-bank fault flags raise the interrupt.
// - Residual bus voltage flag while unattached, enabled.
// - Thermal warning flag at warning threshold.
// - Thermal warning with foldback lowers current outputs.
// - Input pin overvoltage sets bit 2.
// - Data line overvoltage sets bit 1.
// - Read clears flag only once condition gone.
// - Live Type-C sink present in status bit 4.
// - Live charge-detect sink present in bit 3.
// - Bus below safe level bit, Type-C enabled.
// - Bus power applied bit, live in every state.
// - Two-bit plug orientation in bits 5:4.
// - Four-bit connection state code in bits 3:0.
// - Eight-bit load current code, read only.
// - Eight-bit output voltage code, read only.
// - Measurement complete flag, cleared by read.
// - Connection change event flag, cleared by read.
`timescale 1ns/1ps
`include "cfsr_consts.svh"

module cfsr_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Analog comparator levels, asynchronous to the clock.
  input wire logic i_typec_enable,
  input wire logic i_typec_sink_present,
  input wire logic i_charge_detect_sink_present,
  input wire logic i_bus_above_safe_level,
  input wire logic i_thermal_warning_cond,
  input wire logic i_input_overvoltage_cond,
  input wire logic i_dataline_overvoltage_cond,
  input wire logic i_bus_power_applied,
  input wire logic i_foldback_enable,
  // Same-clock inputs from the Type-C state machine, the mask and the converter.
  input wire logic [1:0] i_plug_orientation,
  input wire logic [3:0] i_connection_state_code,
  input wire logic [7:0] i_irq_mask,
  input wire logic i_adc_valid,
  input wire logic [7:0] i_load_current_code,
  input wire logic [7:0] i_output_voltage_code,
  // Register read port behind the serial configuration bus.
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  // Interrupt and thermal foldback outputs.
  output logic o_irq,
  output logic o_reduce_current_adv,
  output logic o_reduce_current_limit
);

  // ---------------------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------------------

  // Reset synchroniser stages; the second stage is the design's reset.
  logic rst_meta_q;
  logic rst_sync_q;

  // Reset is asserted at once but released only after two clean edges.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Raw comparator levels gathered into one vector for synchronising.
  logic [8:0] async_in;
  // First synchroniser stage; only the second stage reads it.
  logic [8:0] sync_meta_q;
  // Second synchroniser stage; all logic reads this copy.
  logic [8:0] sync_q;

  assign async_in = {i_foldback_enable, i_bus_power_applied, i_dataline_overvoltage_cond,
                     i_input_overvoltage_cond, i_thermal_warning_cond, i_bus_above_safe_level,
                     i_charge_detect_sink_present, i_typec_sink_present, i_typec_enable};

  // Two flip-flops per level keep metastability away from the flag logic.
  always_ff @(posedge i_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sync_meta_q <= 9'h000;
      sync_q <= 9'h000;
    end else begin
      sync_meta_q <= async_in;
      sync_q <= sync_meta_q;
    end
  end

  // Named views of the synchronised levels.
  logic typec_en_s;
  logic sink_s;
  logic charge_s;
  logic above_s;
  logic thermal_s;
  logic inov_s;
  logic dataov_s;
  logic power_s;
  logic foldback_s;

  assign typec_en_s = sync_q[0];
  assign sink_s = sync_q[1];
  assign charge_s = sync_q[2];
  assign above_s = sync_q[3];
  assign thermal_s = sync_q[4];
  assign inov_s = sync_q[5];
  assign dataov_s = sync_q[6];
  assign power_s = sync_q[7];
  assign foldback_s = sync_q[8];

  // ---------------------------------------------------------------------------
  // Helper function
  // ---------------------------------------------------------------------------

  // Sticky flag update: a true condition always wins over a clearing read.
  function automatic logic flag_next(input logic flag, input logic cond, input logic clr);
    flag_next = cond | (flag & ~clr);
  endfunction : flag_next

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------

  cfsr_pkg::cfsr_byte_t fault2_q, fault2_d; // Second fault bank.
  cfsr_pkg::cfsr_byte_t events_q, events_d; // Measurement and state-change events.
  cfsr_pkg::cfsr_byte_t status0_q, status0_d; // Live attach and bus status.
  logic [1:0] orient_q, orient_d; // Plug orientation field.
  cfsr_pkg::cfsr_connection_state_code_e conn_q, conn_d; // Connection state code.
  cfsr_pkg::cfsr_byte_t adc_i_q, adc_i_d; // Load current code.
  cfsr_pkg::cfsr_byte_t adc_v_q, adc_v_d; // Output voltage code.
  logic rd_valid_d; // Read answer strobe.
  cfsr_pkg::cfsr_byte_t rd_data_d; // Read answer data.
  logic irq_d; // Interrupt level.
  logic fold_d; // Thermal foldback level.
  logic rd_fault2; // Read of the fault bank this cycle.
  logic rd_events; // Read of the event register this cycle.
  logic conn_change; // Incoming state code differs from the stored one.

  // Decode the read strobes once for all clear-on-read bits.
  assign rd_fault2 = i_rd_en && (i_rd_addr == `CFSR_ADDR_FAULT2);
  assign rd_events = i_rd_en && (i_rd_addr == `CFSR_ADDR_EVENTS);
  assign conn_change = (i_connection_state_code != 4'(conn_q));

  // Next values for every register. There is no write path, so host writes
  // to any of these addresses cannot alter them.
  always_comb begin
    fault2_d = `CFSR_RST_BYTE;
    events_d = `CFSR_RST_BYTE;
    status0_d = `CFSR_RST_BYTE;
    // Each flag follows its cause; a read clears only a flag whose cause is gone.
    fault2_d[`CFSR_F2_RESIDUAL] = flag_next(fault2_q[`CFSR_F2_RESIDUAL],
        typec_en_s & ~sink_s & above_s, rd_fault2);
    fault2_d[`CFSR_F2_THERMAL] = flag_next(fault2_q[`CFSR_F2_THERMAL],
        thermal_s, rd_fault2);
    fault2_d[`CFSR_F2_INOV] = flag_next(fault2_q[`CFSR_F2_INOV],
        inov_s, rd_fault2);
    fault2_d[`CFSR_F2_DATAOV] = flag_next(fault2_q[`CFSR_F2_DATAOV],
        dataov_s, rd_fault2);
    // Event flags are one-shot; the set still wins over a same-cycle read.
    events_d[`CFSR_EV_ADC] = flag_next(events_q[`CFSR_EV_ADC],
        i_adc_valid, rd_events);
    events_d[`CFSR_EV_CHANGE] = flag_next(events_q[`CFSR_EV_CHANGE],
        conn_change, rd_events);
    // Live status bits, refreshed every cycle.
    status0_d[`CFSR_ST0_SINK] = sink_s;
    status0_d[`CFSR_ST0_CHARGE] = charge_s;
    // Outside Type-C operation the safe indication is meaningless and reads 0.
    status0_d[`CFSR_ST0_SAFE] = typec_en_s & ~above_s;
    status0_d[`CFSR_ST0_POWER] = power_s;
    orient_d = i_plug_orientation;
    conn_d = cfsr_pkg::cfsr_connection_state_code_e'(i_connection_state_code);
    // Measurements only move when the converter reports a new result.
    adc_i_d = i_adc_valid ? i_load_current_code : adc_i_q;
    adc_v_d = i_adc_valid ? i_output_voltage_code : adc_v_q;
    irq_d = |(fault2_q & i_irq_mask);
    fold_d = fault2_q[`CFSR_F2_THERMAL] & foldback_s;
    // Read mux; the answer shows the value before any clear takes effect.
    rd_valid_d = i_rd_en;
    rd_data_d = o_rd_data;
    if (i_rd_en) begin
      case (i_rd_addr)
        `CFSR_ADDR_EVENTS: begin
          rd_data_d = events_q & `CFSR_EV_USED;
        end
        `CFSR_ADDR_FAULT2: begin
          rd_data_d = fault2_q & `CFSR_F2_USED;
        end
        `CFSR_ADDR_STATUS0: begin
          rd_data_d = status0_q & `CFSR_ST0_USED;
        end
        `CFSR_ADDR_STATUS1: begin
          rd_data_d = {2'b00, orient_q, 4'(conn_q)};
        end
        `CFSR_ADDR_ADC_I: begin
          rd_data_d = adc_i_q;
        end
        `CFSR_ADDR_ADC_V: begin
          rd_data_d = adc_v_q;
        end
        default: begin
          // Unmapped offsets answer with zero rather than stale data.
          rd_data_d = `CFSR_RST_BYTE;
        end
      endcase
    end
  end

  // Register everything; reset brings every register to zero.
  always_ff @(posedge i_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fault2_q <= `CFSR_RST_BYTE;
      events_q <= `CFSR_RST_BYTE;
      status0_q <= `CFSR_RST_BYTE;
      orient_q <= 2'b00;
      conn_q <= cfsr_pkg::CFSR_CC_DISABLED;
      adc_i_q <= `CFSR_RST_BYTE;
      adc_v_q <= `CFSR_RST_BYTE;
      o_rd_valid <= 1'b0;
      o_rd_data <= `CFSR_RST_BYTE;
      o_irq <= 1'b0;
      o_reduce_current_adv <= 1'b0;
      o_reduce_current_limit <= 1'b0;
    end else begin
      fault2_q <= fault2_d;
      events_q <= events_d;
      status0_q <= status0_d;
      orient_q <= orient_d;
      conn_q <= conn_d;
      adc_i_q <= adc_i_d;
      adc_v_q <= adc_v_d;
      o_rd_valid <= rd_valid_d;
      o_rd_data <= rd_data_d;
      o_irq <= irq_d;
      o_reduce_current_adv <= fold_d;
      o_reduce_current_limit <= fold_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------

  // A host read of the fault bank.
  sequence s_read_fault2;
    i_rd_en && (i_rd_addr == `CFSR_ADDR_FAULT2);
  endsequence

  // A residual-voltage cause held over two cycles.
  sequence s_residual_cause;
    (typec_en_s && !sink_s && above_s) [*2];
  endsequence

  a_residual_flag_set: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    s_residual_cause |=> fault2_q[`CFSR_F2_RESIDUAL])
    else $error("residual voltage flag not set");

  a_thermal_flag_set: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    $rose(thermal_s) |=> fault2_q[`CFSR_F2_THERMAL])
    else $error("thermal warning flag not set");

  a_inov_flag_set: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    inov_s |=> fault2_q[`CFSR_F2_INOV])
    else $error("input overvoltage flag not set");

  a_dataov_flag_set: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    dataov_s |=> fault2_q[`CFSR_F2_DATAOV])
    else $error("data line overvoltage flag not set");

  a_read_clear_fault: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    s_read_fault2 |=> (fault2_q[`CFSR_F2_THERMAL] == $past(thermal_s))
      && (fault2_q[`CFSR_F2_INOV] == $past(inov_s)))
    else $error("fault read clear wrong");

  a_flag_holds_unread: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    fault2_q[`CFSR_F2_DATAOV] && !i_rd_en |=> fault2_q[`CFSR_F2_DATAOV])
    else $error("fault flag lost without read");

  // Any enabled fault flag must show on the interrupt one cycle later.
  a_irq_masked_flag: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    (|(fault2_q & i_irq_mask)) |=> o_irq)
    else $error("masked fault did not raise interrupt");

  a_foldback_follow: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    ##1 (o_reduce_current_adv && o_reduce_current_limit)
      == $past(fault2_q[`CFSR_F2_THERMAL] && foldback_s))
    else $error("foldback outputs wrong");

  a_safe_status: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    !typec_en_s |=> !status0_q[`CFSR_ST0_SAFE])
    else $error("safe bit set with Type-C off");

  a_adc_capture: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    i_adc_valid |=> (adc_i_q == $past(i_load_current_code)) && events_q[`CFSR_EV_ADC])
    else $error("measurement not captured");

  a_state_change_ev: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    conn_change |=> events_q[`CFSR_EV_CHANGE])
    else $error("state change event missed");

  a_unused_zero: assert property (@(posedge i_clk) disable iff (!rst_sync_q)
    o_rd_valid && $past(i_rd_addr) == `CFSR_ADDR_FAULT2 |-> (o_rd_data & ~`CFSR_F2_USED) == 8'h00)
    else $error("unused fault bits read nonzero");

endmodule : cfsr_regs

// >>> test/cfsr_host_model.sv
// Host processor model that reads the device registers one byte at a time.
`timescale 1ns/1ps

module cfsr_host_model (
  input wire logic i_clk,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_en,
  output logic [7:0] o_rd_addr
);
  // ---------------------------------------------------------------------------
  // Idle bus
  // ---------------------------------------------------------------------------
  // The port starts idle so no read is taken during reset.
  initial begin
    o_rd_en = 1'b0;
    o_rd_addr = 8'h00;
  end

  // ---------------------------------------------------------------------------
  // Read cycle
  // ---------------------------------------------------------------------------
  // Strobe for one cycle and take the byte on the answer cycle. A released
  // address shows its inverse, so a stale value never looks like a fresh one.
  task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b1;
    o_rd_addr = addr;
    @(posedge i_clk);
    #1;
    ok = i_rd_valid;
    data = i_rd_data;
    o_rd_en = 1'b0;
    o_rd_addr = ~addr;
  endtask : read
endmodule : cfsr_host_model

// >>> test/cfsr_regs_tb_top.sv
// Self-checking testbench for the charger fault and status registers.
`timescale 1ns/1ps
`include "cfsr_consts.svh"

module cfsr_regs_tb_top;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic clk, rst_n, tc_en, sink, chg, above, thm, inov, dov, pwr, fold, adc_v;
  logic rd_en, rd_valid, irq, red_adv, red_lim;
  logic [1:0] orient;
  logic [3:0] state;
  logic [7:0] mask, cur, volt, rd_addr, rd_data;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  cfsr_regs u_cfsr_regs (.i_clk(clk), .i_rst_n(rst_n), .i_typec_enable(tc_en),
    .i_typec_sink_present(sink), .i_charge_detect_sink_present(chg),
    .i_bus_above_safe_level(above), .i_thermal_warning_cond(thm),
    .i_input_overvoltage_cond(inov), .i_dataline_overvoltage_cond(dov),
    .i_bus_power_applied(pwr), .i_foldback_enable(fold), .i_plug_orientation(orient),
    .i_connection_state_code(state), .i_irq_mask(mask), .i_adc_valid(adc_v),
    .i_load_current_code(cur), .i_output_voltage_code(volt), .i_rd_en(rd_en),
    .i_rd_addr(rd_addr), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_irq(irq),
    .o_reduce_current_adv(red_adv), .o_reduce_current_limit(red_lim));

  cfsr_host_model u_cfsr_host_model (.i_clk(clk), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .o_rd_en(rd_en), .o_rd_addr(rd_addr));

  // ---------------------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------------------
  // The run needs well under a thousand cycles; the ceiling leaves ample margin.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Inputs change one nanosecond after the edge, away from the sampling point.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Compares one byte with case inequality so an unknown never passes.
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Reads one register and checks both the answer strobe and the byte.
  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] data;
    logic ok;
    u_cfsr_host_model.read(addr, data, ok);
    check({name, " valid"}, 8'h01, {7'h00, ok});
    check(name, exp, data);
  endtask : rd_chk

  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Every mapped register and two holes read zero straight after reset.
  task automatic sc_reset_values();
    logic [7:0] addrs [8] = '{8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h0F, 8'hFF};
    foreach (addrs[i]) rd_chk("reset byte", addrs[i], 8'h00);
    check("reset irq", 8'h00, {7'h00, irq});
  endtask : sc_reset_values

  // Thermal and input flags; one condition goes away while the other persists.
  task automatic sc_fault_clear();
    thm = 1'b1;
    inov = 1'b1;
    step(5);
    check("foldback disabled", 8'h00, {6'h00, red_adv, red_lim});
    fold = 1'b1;
    step(3);
    check("foldback", 8'h03, {6'h00, red_adv, red_lim});
    rd_chk("fault bank", `CFSR_ADDR_FAULT2, 8'h0C);
    inov = 1'b0;
    step(4);
    rd_chk("fault sticky", `CFSR_ADDR_FAULT2, 8'h0C);
    rd_chk("fault partial", `CFSR_ADDR_FAULT2, 8'h08);
    thm = 1'b0;
    step(4);
    rd_chk("fault last", `CFSR_ADDR_FAULT2, 8'h08);
    rd_chk("fault empty", `CFSR_ADDR_FAULT2, 8'h00);
    step(1);
    check("foldback off", 8'h00, {6'h00, red_adv, red_lim});
    fold = 1'b0;
  endtask : sc_fault_clear

  // Residual bus voltage and data overvoltage, seen through the mask.
  task automatic sc_residual_irq();
    tc_en = 1'b1;
    above = 1'b1;
    dov = 1'b1;
    mask = 8'h02;
    step(5);
    check("irq raised", 8'h01, {7'h00, irq});
    rd_chk("fault pair", `CFSR_ADDR_FAULT2, 8'h22);
    rd_chk("status unsafe", `CFSR_ADDR_STATUS0, 8'h00);
    dov = 1'b0;
    above = 1'b0;
    mask = 8'h20;
    step(4);
    check("irq masked bit", 8'h01, {7'h00, irq});
    rd_chk("fault pair again", `CFSR_ADDR_FAULT2, 8'h22);
    step(2);
    check("irq cleared", 8'h00, {7'h00, irq});
    rd_chk("status safe", `CFSR_ADDR_STATUS0, 8'h04);
  endtask : sc_residual_irq

  // Live status bits follow their inputs; below-safe reads 0 with Type-C off.
  task automatic sc_status();
    sink = 1'b1;
    chg = 1'b1;
    pwr = 1'b1;
    step(4);
    rd_chk("status all", `CFSR_ADDR_STATUS0, 8'h1D);
    tc_en = 1'b0;
    pwr = 1'b0;
    step(4);
    rd_chk("status typec off", `CFSR_ADDR_STATUS0, 8'h18);
    sink = 1'b0;
    chg = 1'b0;
  endtask : sc_status

  // A measurement pair is captured on the valid pulse only.
  task automatic sc_adc();
    cur = 8'hA5;
    volt = 8'h5A;
    adc_v = 1'b1;
    step(1);
    adc_v = 1'b0;
    cur = 8'h00;
    volt = 8'hFF;
    rd_chk("load current", `CFSR_ADDR_ADC_I, 8'hA5);
    rd_chk("output voltage", `CFSR_ADDR_ADC_V, 8'h5A);
    rd_chk("adc done", `CFSR_ADDR_EVENTS, 8'h01);
    rd_chk("adc done clear", `CFSR_ADDR_EVENTS, 8'h00);
  endtask : sc_adc

  // Every state code except the disabled code 0, with a rotating orientation, and the change event.
  task automatic sc_connection();
    logic [3:0] codes [5] = '{4'h2, 4'h3, 4'h6, 4'h8, 4'hC};
    foreach (codes[i]) begin
      state = codes[i];
      orient = 2'(i % 3);
      step(2);
      rd_chk("conn state", `CFSR_ADDR_STATUS1, {2'b00, orient, state});
      rd_chk("conn event", `CFSR_ADDR_EVENTS, 8'h20);
      rd_chk("conn event clear", `CFSR_ADDR_EVENTS, 8'h00);
    end
  endtask : sc_connection

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, tc_en, sink, chg, above, thm, inov, dov, pwr, fold, adc_v} = '0;
    orient = 2'b00;
    state = 4'h0;
    mask = 8'h00;
    cur = 8'h00;
    volt = 8'h00;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(4);
    sc_reset_values();
    sc_fault_clear();
    sc_residual_irq();
    sc_status();
    sc_adc();
    sc_connection();
    tally_and_finish();
  end
endmodule : cfsr_regs_tb_top
